// >>> lsc_logic_block.sv
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "lsc_defines.svh"
// ----------------------------------------
// Functional notes
// - each cell has a four-input table, carry logic and one storage element.
// - table output feeds both cell output and the flop data input.
// - four cells per block, two identical slices of two cells.
// - extra muxes join tables into five- and six-input functions.
// - each table can act as a sixteen by one synchronous ram.
// - slice tables combine as 16x2, 32x1 or 16x1 dual-port ram.
// - each table can act as a sixteen-stage shift register.
// - storage element is either edge flop or transparent latch.
// - storage data comes from table output or direct slice input.
// - each slice has clock and clock enable for its storage.
// - init force drives storage to its configured initial value.
// - invert force drives storage to the complement of initial value.
// - forces act synchronously by default, asynchronously when configured.
// - each slice control invertible, shared by both slice flops.
// ----------------------------------------
module lsc_logic_block (
  input  wire logic                               sys_clk,
  input  wire logic                               sys_rst,
  input  wire lsc_pkg::lsc_addr_t                 regAddr,
  input  wire lsc_pkg::lsc_data_t                 regWdata,
  input  wire logic                               regWr,
  input  wire logic                               regRd,
  output lsc_pkg::lsc_data_t                      regRdata,
  input  wire logic [`LSC_SLICES-1:0]             sliceClk,
  input  wire logic [`LSC_SLICES-1:0]             sliceCe,
  input  wire logic [`LSC_SLICES-1:0]             initForce,
  input  wire logic [`LSC_SLICES-1:0]             invertForce,
  input  wire logic [`LSC_SLICES-1:0]             sliceWe,
  input  wire logic [`LSC_SLICES-1:0]             f5Sel,
  input  wire logic                               f6Sel,
  input  wire logic                               carryIn,
  input  wire logic [`LSC_CELLS*`LSC_LUT_IN-1:0]  lutIn,
  input  wire logic [`LSC_CELLS-1:0]              directIn,
  output logic      [`LSC_CELLS-1:0]              cellOut,
  output logic      [`LSC_CELLS-1:0]              cellQ,
  output logic      [`LSC_SLICES-1:0]             f5Out,
  output logic                                    f6Out,
  output logic                                    carryOut
);
  import lsc_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic isRam(input lsc_mode_e m);
    isRam = (m == LSC_RAM1) || (m == LSC_RAM2) || (m == LSC_RAM32) || (m == LSC_RAMDP);
  endfunction

  function automatic logic sharedAddr(input lsc_mode_e m);
    sharedAddr = (m == LSC_RAM2) || (m == LSC_RAM32);
  endfunction

  // ----------------------------------------
  // state and nets
  // ----------------------------------------
  lsc_cfg_t                  sliceCfg [`LSC_SLICES];
  logic [`LSC_SLICES-1:0]    clkPrev;
  logic [`LSC_SLICES-1:0]    clkLvl;
  logic [`LSC_SLICES-1:0]    clkEdge;
  logic [`LSC_SLICES-1:0]    ceLvl;
  logic [`LSC_SLICES-1:0]    initLvl;
  logic [`LSC_SLICES-1:0]    invLvl;
  logic [`LSC_SLICES-1:0]    weLvl;
  logic [`LSC_SLICES-1:0]    tableEdge;
  logic [`LSC_SLICES-1:0]    f5Comb;
  lsc_mode_e                 mode [`LSC_SLICES];
  lsc_lut_t                  lutBits [`LSC_CELLS];
  logic [`LSC_CELLS-1:0]     lutOut;
  logic [`LSC_CELLS-1:0]     sumOut;
  logic [`LSC_CELLS-1:0]     outComb;
  logic [`LSC_CELLS-1:0]     lutLoad;
  logic [`LSC_CELLS:0]       carry;
  logic                      f6Comb;
  logic                      wordOk;
  lsc_data_t                 next_regRdata;
  lsc_data_t                 statusWord;
  logic [$clog2(`LSC_CELLS)-1:0] lutIdx;

  assign carry[0] = carryIn;

  // ----------------------------------------
  // slices
  // ----------------------------------------
  // two slices of two cells
  for (genvar s = 0; s < `LSC_SLICES; s++) begin : g_slice
    // per-control inversion, shared by both cells
    assign mode[s]    = lsc_mode_e'(sliceCfg[s][`LSC_F_MODE]);
    assign clkLvl[s]  = sliceClk[s] ^ sliceCfg[s][`LSC_B_INVCLK];
    assign ceLvl[s]   = sliceCe[s] ^ sliceCfg[s][`LSC_B_INVCE];
    assign initLvl[s] = initForce[s] ^ sliceCfg[s][`LSC_B_INVINIT];
    assign invLvl[s]  = invertForce[s] ^ sliceCfg[s][`LSC_B_INVINV];
    assign weLvl[s]   = sliceWe[s] ^ sliceCfg[s][`LSC_B_INVWE];
    // slice clock is sampled, so an edge is seen one sys_clk late
    assign clkEdge[s] = clkLvl[s] & ~clkPrev[s];
    // table edge needs clock edge, ce and we
    assign tableEdge[s] = clkEdge[s] & ceLvl[s] & weLvl[s];
    // five-input function from the slice pair
    assign f5Comb[s] = f5Sel[s] ? lutOut[s*`LSC_CPS+1] : lutOut[s*`LSC_CPS];

    for (genvar j = 0; j < `LSC_CPS; j++) begin : g_cell
      localparam int C = s * `LSC_CPS + j;
      localparam int B = s * `LSC_CPS;
      logic [`LSC_LUT_IN-1:0] ownAddr;
      logic [`LSC_LUT_IN-1:0] baseAddr;
      logic [`LSC_LUT_IN-1:0] wrAddr;
      logic [`LSC_LUT_IN-1:0] rdAddr;
      logic                   wrData;
      logic                   wrEn;
      logic                   shiftEn;
      logic                   dSel;

      assign ownAddr  = lutIn[C*`LSC_LUT_IN +: `LSC_LUT_IN];
      assign baseAddr = lutIn[B*`LSC_LUT_IN +: `LSC_LUT_IN];
      // paired modes write at the first cell's address; dual-port reads at its own
      assign wrAddr = (mode[s] == LSC_RAM1) ? ownAddr : baseAddr;
      assign rdAddr = sharedAddr(mode[s]) ? baseAddr : ownAddr;
      assign wrData = (mode[s] == LSC_RAM1 || mode[s] == LSC_RAM2) ?
                      directIn[C] : directIn[B];
      // 32x1 picks the half with f5Sel as top address bit
      assign wrEn = tableEdge[s] & isRam(mode[s]) &
                    ((mode[s] != LSC_RAM32) || (f5Sel[s] == 1'(j)));
      // serial data enters on the cell direct input
      assign shiftEn = tableEdge[s] & (mode[s] == LSC_SHIFT);
      assign lutLoad[C] = regWr & wordOk &
                          (regAddr[`LSC_F_LUTIDX] == 2'(C)) &
                          (regAddr < `LSC_OFS_CFG0);

      // table storage, also ram and shift register
      lsc_lut_mem #(
        .DEPTH (`LSC_LUT_DEPTH)
      ) u_lut (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .load     (lutLoad[C]),
        .loadData (regWdata[`LSC_LUT_DEPTH-1:0]),
        .wrEn     (wrEn),
        .wrAddr   (wrAddr),
        .wrData   (wrData),
        .shiftEn  (shiftEn),
        .shiftIn  (directIn[C]),
        .bits     (lutBits[C])
      );

      assign lutOut[C] = lutBits[C][rdAddr];
      // carry passes when table is one, else first input
      assign carry[C+1] = lutOut[C] ? carry[C] : ownAddr[0];
      assign sumOut[C]  = lutOut[C] ^ carry[C];
      assign outComb[C] = sliceCfg[s][`LSC_B_OSEL0 + j] ? sumOut[C] : lutOut[C];
      // flop data from table or direct input
      assign dSel = sliceCfg[s][`LSC_B_DSEL0 + j];

      // async option lets forces bypass the slice edge
      lsc_store_elem u_store (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .dIn        (dSel ? directIn[C] : lutOut[C]),
        .ceLvl      (ceLvl[s]),
        .clkEdge    (clkEdge[s]),
        .gateOpen   (clkLvl[s]),
        .isLatch    (sliceCfg[s][`LSC_B_LATCH0 + j]),
        .asyncForce (sliceCfg[s][`LSC_B_ASYNC]),
        .initLvl    (initLvl[s]),
        .invLvl     (invLvl[s]),
        .initVal    (sliceCfg[s][`LSC_B_INITV0 + j]),
        .q          (cellQ[C])
      );
    end
  end

  assign f6Comb = f6Sel ? f5Comb[1] : f5Comb[0];

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  assign wordOk = regAddr[`LSC_F_WORD] == '0;
  assign lutIdx = regAddr[`LSC_F_LUTIDX];
  assign statusWord = `LSC_DATA_W'({carryOut, f6Out, f5Out, cellOut, cellQ});
  // unmapped or unaligned reads return zero
  assign next_regRdata =
    !regRd                                ? '0 :
    (wordOk && regAddr < `LSC_OFS_CFG0)   ? `LSC_DATA_W'(lutBits[lutIdx]) :
    (regAddr == `LSC_OFS_CFG0)            ? `LSC_DATA_W'(sliceCfg[0]) :
    (regAddr == `LSC_OFS_CFG1)            ? `LSC_DATA_W'(sliceCfg[1]) :
    (regAddr == `LSC_OFS_STAT)            ? statusWord : '0;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sliceCfg[0] <= `LSC_CFG_RST;
      sliceCfg[1] <= `LSC_CFG_RST;
    end else if (regWr && regAddr == `LSC_OFS_CFG0) begin
      sliceCfg[0] <= regWdata[`LSC_CFG_W-1:0];
    end else if (regWr && regAddr == `LSC_OFS_CFG1) begin
      sliceCfg[1] <= regWdata[`LSC_CFG_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clkPrev  <= '0;
      regRdata <= '0;
    end else begin
      clkPrev  <= clkLvl;
      regRdata <= next_regRdata;
    end
  end

  // outputs are flopped, so combinational paths show one cycle late
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cellOut  <= '0;
      f5Out    <= '0;
      f6Out    <= 1'b0;
      carryOut <= 1'b0;
    end else begin
      cellOut  <= outComb;
      f5Out    <= f5Comb;
      f6Out    <= f6Comb;
      carryOut <= carry[`LSC_CELLS];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_gen_drives_out: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !sliceCfg[0][`LSC_B_OSEL0] |=> cellOut[0] == $past(lutOut[0]))
    else $error("cell output not table output");

  a_wide_func: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (f6Sel && f5Sel[1]) |=> f6Out == $past(lutOut[3]))
    else $error("six-input mux wrong");

  a_read_unmapped: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (regRd && regAddr > `LSC_OFS_STAT) |=> regRdata == '0)
    else $error("unmapped read not zero");

  a_read_cfg: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (regRd && regAddr == `LSC_OFS_CFG0) |=> regRdata == `LSC_DATA_W'($past(sliceCfg[0])))
    else $error("config read wrong");

  // read data stand one cycle, so a late sampler sees zero
  a_read_idle: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !regRd |=> regRdata == '0)
    else $error("read data held past its cycle");

  a_ram32_half: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (mode[0] == LSC_RAM32 && f5Sel[0] && !lutLoad[0]) |=> $stable(lutBits[0]))
    else $error("wide ram wrote the wrong half");

  a_dp_same_word: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (mode[0] == LSC_RAMDP && tableEdge[0] && !lutLoad[0] && !lutLoad[1]) |=>
      lutBits[0][$past(lutIn[`LSC_LUT_IN-1:0])] == lutBits[1][$past(lutIn[`LSC_LUT_IN-1:0])])
    else $error("dual-port tables differ at write address");

  a_ram2_own_data: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (mode[0] == LSC_RAM2 && tableEdge[0] && !lutLoad[1]) |=>
      lutBits[1][$past(lutIn[`LSC_LUT_IN-1:0])] == $past(directIn[1]))
    else $error("two-bit ram upper bit lost");

  a_we_low_holds: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (!weLvl[0] && !lutLoad[0]) |=> $stable(lutBits[0]))
    else $error("table moved with write enable low");

  a_flop_holds: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (!clkEdge[0] && !sliceCfg[0][`LSC_B_LATCH0] && !sliceCfg[0][`LSC_B_ASYNC]) |=>
      $stable(cellQ[0]))
    else $error("flop moved between slice edges");

  a_direct_path: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (clkEdge[0] && ceLvl[0] && !initLvl[0] && !invLvl[0] && sliceCfg[0][`LSC_B_DSEL0] &&
     !sliceCfg[0][`LSC_B_LATCH0]) |=> cellQ[0] == $past(directIn[0]))
    else $error("flop missed the direct input");

  a_async_init: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (initLvl[0] && sliceCfg[0][`LSC_B_ASYNC]) |=>
      cellQ[0] == $past(sliceCfg[0][`LSC_B_INITV0]))
    else $error("init force missed configured value");

  a_carry_pass: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    lutOut[3] |=> carryOut == $past(carry[3]))
    else $error("carry did not propagate");
endmodule

// >>> lsc_defines.svh
`ifndef LSC_DEFINES_SVH
`define LSC_DEFINES_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define LSC_ADDR_W     8
`define LSC_DATA_W     32
`define LSC_LUT_DEPTH  16
`define LSC_LUT_IN     4
`define LSC_CELLS      4
`define LSC_SLICES     2
`define LSC_CPS        2
`define LSC_CFG_W      17

// ----------------------------------------
// register offsets
// ----------------------------------------
`define LSC_OFS_LUT0   8'h00
`define LSC_OFS_CFG0   8'h10
`define LSC_OFS_CFG1   8'h14
`define LSC_OFS_STAT   8'h18
`define LSC_F_WORD     1:0
`define LSC_F_LUTIDX   3:2

// ----------------------------------------
// slice config fields
// ----------------------------------------
`define LSC_F_MODE     2:0
`define LSC_B_LATCH0   3
`define LSC_B_ASYNC    5
`define LSC_B_INVCLK   6
`define LSC_B_INVCE    7
`define LSC_B_INVINIT  8
`define LSC_B_INVINV   9
`define LSC_B_INVWE    10
`define LSC_B_INITV0   11
`define LSC_B_DSEL0    13
`define LSC_B_OSEL0    15

// ----------------------------------------
// reset values
// ----------------------------------------
`define LSC_CFG_RST    17'h00000
`define LSC_LUT_RST    16'h0000

`endif

// >>> lsc_pkg.sv
`include "lsc_defines.svh"
package lsc_pkg;
  typedef logic [`LSC_ADDR_W-1:0]    lsc_addr_t;
  typedef logic [`LSC_DATA_W-1:0]    lsc_data_t;
  typedef logic [`LSC_LUT_DEPTH-1:0] lsc_lut_t;
  typedef logic [`LSC_CFG_W-1:0]     lsc_cfg_t;
  typedef enum logic [2:0] {
    LSC_LOGIC  = 3'b000,
    LSC_RAM1   = 3'b001,
    LSC_RAM2   = 3'b010,
    LSC_RAM32  = 3'b011,
    LSC_RAMDP  = 3'b100,
    LSC_SHIFT  = 3'b101
  } lsc_mode_e;
endpackage

// >>> lsc_lut_mem.sv
`timescale 1ns/1ps
`include "lsc_defines.svh"
module lsc_lut_mem #(
  parameter int DEPTH = `LSC_LUT_DEPTH
) (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     load,
  input  wire logic [DEPTH-1:0]         loadData,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic                     wrData,
  input  wire logic                     shiftEn,
  input  wire logic                     shiftIn,
  output logic      [DEPTH-1:0]         bits
);
  import lsc_pkg::*;

  logic [DEPTH-1:0] oneHot;
  logic [DEPTH-1:0] next_bits;

  // config load wins over user writes
  assign oneHot    = DEPTH'(1) << wrAddr;
  assign next_bits = load    ? loadData :
                     wrEn    ? ((bits & ~oneHot) | ({DEPTH{wrData}} & oneHot)) :
                     shiftEn ? {bits[DEPTH-2:0], shiftIn} : bits;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bits <= DEPTH'(`LSC_LUT_RST);
    end else begin
      bits <= next_bits;
    end
  end

  a_ram_write_lands: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (wrEn && !load) |=> bits[$past(wrAddr)] == $past(wrData))
    else $error("ram write lost");

  a_shift_moves: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (shiftEn && !wrEn && !load) |=> bits == {$past(bits[DEPTH-2:0]), $past(shiftIn)})
    else $error("shift register did not advance");

  a_table_quiet: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (!load && !wrEn && !shiftEn) |=> $stable(bits))
    else $error("table changed without write");
endmodule

// >>> lsc_store_elem.sv
`timescale 1ns/1ps
module lsc_store_elem (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic dIn,
  input  wire logic ceLvl,
  input  wire logic clkEdge,
  input  wire logic gateOpen,
  input  wire logic isLatch,
  input  wire logic asyncForce,
  input  wire logic initLvl,
  input  wire logic invLvl,
  input  wire logic initVal,
  output logic      q
);
  import lsc_pkg::*;

  logic anyForce;
  logic forceVal;
  logic takes;
  logic next_q;

  assign anyForce = initLvl | invLvl;
  assign forceVal = initLvl ? initVal : ~initVal;
  // latch takes while gate is open
  assign takes    = isLatch ? gateOpen : clkEdge;
  assign next_q   = (asyncForce && anyForce) ? forceVal :
                    (takes && anyForce)      ? forceVal :
                    (takes && ceLvl)         ? dIn : q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  a_init_wins: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (initLvl && invLvl && (asyncForce || takes)) |=> q == $past(initVal))
    else $error("init force lost priority");

  a_invert_force: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (!initLvl && invLvl && (asyncForce || takes)) |=> q == !$past(initVal))
    else $error("invert force wrong value");

  a_sync_force_waits: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (!asyncForce && !takes) |=> q == $past(q))
    else $error("sync force acted off edge");

  a_latch_follows: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (isLatch && gateOpen && ceLvl && !anyForce) |=> q == $past(dIn))
    else $error("latch not transparent");

  a_ce_holds: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (!isLatch && clkEdge && !ceLvl && !anyForce) |=> $stable(q))
    else $error("flop moved with ce low");
endmodule

// >>> lsc_route_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// slice clock source on the routing side
// ----------------------------------------
module lsc_route_model (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] run,
  output logic      [1:0] sliceClk
);
  // stands low between requests, so no stray edge reaches the slice
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sliceClk <= 2'b00;
    end else begin
      sliceClk <= run & ~sliceClk;
    end
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`include "lsc_defines.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errorCnt++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top;
  import lsc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        sys_clk;
  logic        sys_rst;
  lsc_addr_t   regAddr;
  lsc_data_t   regWdata;
  logic        regWr;
  logic        regRd;
  lsc_data_t   regRdata;
  logic [1:0]  run;
  logic [1:0]  sliceClk;
  logic [1:0]  sliceCe;
  logic [1:0]  initForce;
  logic [1:0]  invertForce;
  logic [1:0]  sliceWe;
  logic [1:0]  f5Sel;
  logic        f6Sel;
  logic        carryIn;
  logic [15:0] lutIn;
  logic [3:0]  directIn;
  logic [3:0]  cellOut;
  logic [3:0]  cellQ;
  logic [1:0]  f5Out;
  logic        f6Out;
  logic        carryOut;
  int          errorCnt;
  int          checked;
  lsc_data_t   v;

  lsc_route_model route (.sys_clk(sys_clk), .sys_rst(sys_rst), .run(run), .sliceClk(sliceClk));

  lsc_logic_block dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sliceClk(sliceClk),
    .sliceCe(sliceCe), .initForce(initForce), .invertForce(invertForce),
    .sliceWe(sliceWe), .f5Sel(f5Sel), .f6Sel(f6Sel), .carryIn(carryIn), .lutIn(lutIn),
    .directIn(directIn), .cellOut(cellOut), .cellQ(cellQ), .f5Out(f5Out),
    .f6Out(f6Out), .carryOut(carryOut)
  );

  // ----------------------------------------
  // bus and slice helpers
  // ----------------------------------------
  task automatic wr(input lsc_addr_t a, input lsc_data_t d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr    <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input lsc_addr_t a, output lsc_data_t d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    #1;
    d = regRdata;
  endtask

  // one slice clock edge, then room for the flop to answer
  task automatic pulse(input int s);
    @(posedge sys_clk);
    run[s] <= 1'b1;
    @(posedge sys_clk);
    run[s] <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(`LSC_OFS_CFG0, v);
    `CHK(v, 32'h0)
    rd(`LSC_OFS_LUT0, v);
    `CHK(v, 32'h0)
    rd(8'h1C, v);
    `CHK(v, 32'h0)
    wr(`LSC_OFS_LUT0 + 8'h04, 32'hAAAA);
    rd(`LSC_OFS_LUT0 + 8'h04, v);
    `CHK(v, 32'hAAAA)
    $display("test regs done");
  endtask

  task automatic t_logic;
    wr(`LSC_OFS_LUT0, 32'h6996);
    wr(`LSC_OFS_LUT0 + 8'h04, 32'hFFFF);
    for (int a = 0; a < 16; a++) begin
      @(posedge sys_clk);
      lutIn[3:0] <= a[3:0];
      settle();
      `CHK(cellOut[0], ^a[3:0])
    end
    `CHK(f5Out[0], 1'b0)
    @(posedge sys_clk);
    f5Sel[0] <= 1'b1;
    settle();
    `CHK(f5Out[0], 1'b1)
    @(posedge sys_clk);
    f5Sel[0]   <= 1'b0;
    lutIn[3:0] <= 4'h7;
    sliceCe    <= 2'b11;
    pulse(0);
    `CHK(cellQ[1:0], 2'b11)
    `CHK(f6Out, 1'b1)
    wr(`LSC_OFS_LUT0 + 8'h0C, 32'hFFFF);
    @(posedge sys_clk);
    f6Sel <= 1'b1;
    settle();
    `CHK(f6Out, 1'b0)
    @(posedge sys_clk);
    f5Sel[1] <= 1'b1;
    settle();
    `CHK(f6Out, 1'b1)
    // all four tables read one, so carry rides straight through
    wr(`LSC_OFS_LUT0 + 8'h08, 32'hFFFF);
    @(posedge sys_clk);
    carryIn <= 1'b1;
    settle();
    `CHK(carryOut, 1'b1)
    @(posedge sys_clk);
    carryIn <= 1'b0;
    settle();
    `CHK(carryOut, 1'b0)
    $display("test logic done");
  endtask

  task automatic t_direct;
    wr(`LSC_OFS_CFG0, 32'h2000);
    @(posedge sys_clk);
    directIn[0] <= 1'b0;
    sliceCe     <= 2'b00;
    pulse(0);
    `CHK(cellQ[0], 1'b1)
    @(posedge sys_clk);
    sliceCe <= 2'b01;
    pulse(0);
    `CHK(cellQ[1:0], 2'b10)
    // inverted enable: low pin now enables
    wr(`LSC_OFS_CFG0, 32'h2080);
    @(posedge sys_clk);
    directIn[0] <= 1'b1;
    sliceCe     <= 2'b00;
    pulse(0);
    `CHK(cellQ[0], 1'b1)
    $display("test direct done");
  endtask

  task automatic t_force;
    wr(`LSC_OFS_CFG0, 32'h0800);
    @(posedge sys_clk);
    invertForce <= 2'b01;
    settle();
    `CHK(cellQ[1:0], 2'b11)
    pulse(0);
    `CHK(cellQ[1:0], 2'b10)
    @(posedge sys_clk);
    initForce <= 2'b01;
    pulse(0);
    `CHK(cellQ[1:0], 2'b01)
    @(posedge sys_clk);
    initForce <= 2'b00;
    wr(`LSC_OFS_CFG0, 32'h0820);
    settle();
    `CHK(cellQ[1:0], 2'b10)
    // inverted init force, low pin asserts it
    wr(`LSC_OFS_CFG0, 32'h0920);
    settle();
    `CHK(cellQ[1:0], 2'b01)
    @(posedge sys_clk);
    invertForce <= 2'b00;
    initForce   <= 2'b01;
    $display("test force done");
  endtask

  task automatic t_ram;
    wr(`LSC_OFS_CFG0, 32'h1);
    wr(`LSC_OFS_LUT0, 32'h0);
    @(posedge sys_clk);
    initForce   <= 2'b00;
    lutIn[3:0]  <= 4'h5;
    directIn[0] <= 1'b1;
    sliceWe     <= 2'b01;
    sliceCe     <= 2'b01;
    pulse(0);
    rd(`LSC_OFS_LUT0, v);
    `CHK(v, 32'h20)
    `CHK(cellOut[0], 1'b1)
    @(posedge sys_clk);
    lutIn[3:0] <= 4'h6;
    sliceCe    <= 2'b00;
    pulse(0);
    @(posedge sys_clk);
    sliceCe <= 2'b01;
    sliceWe <= 2'b00;
    pulse(0);
    rd(`LSC_OFS_LUT0, v);
    `CHK(v, 32'h20)
    $display("test ram done");
  endtask

  task automatic t_shift;
    wr(`LSC_OFS_CFG0, 32'h5);
    wr(`LSC_OFS_LUT0, 32'h0);
    @(posedge sys_clk);
    sliceWe <= 2'b01;
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      directIn[0] <= (i == 0);
      pulse(0);
    end
    rd(`LSC_OFS_LUT0, v);
    `CHK(v, 32'h4)
    @(posedge sys_clk);
    lutIn[3:0] <= 4'h2;
    settle();
    `CHK(cellOut[0], 1'b1)
    $display("test shift done");
  endtask

  task automatic t_pair;
    wr(`LSC_OFS_CFG0, 32'h2);
    wr(`LSC_OFS_LUT0, 32'h0);
    wr(`LSC_OFS_LUT0 + 8'h04, 32'h0);
    @(posedge sys_clk);
    lutIn[7:0]    <= 8'hF3;
    directIn[1:0] <= 2'b10;
    pulse(0);
    rd(`LSC_OFS_LUT0 + 8'h04, v);
    `CHK(v, 32'h8)
    `CHK(cellOut[1], 1'b1)
    wr(`LSC_OFS_CFG0, 32'h3);
    @(posedge sys_clk);
    f5Sel[0]    <= 1'b1;
    directIn[0] <= 1'b1;
    lutIn[3:0]  <= 4'h9;
    pulse(0);
    rd(`LSC_OFS_LUT0, v);
    `CHK(v, 32'h0)
    `CHK(f5Out[0], 1'b1)
    wr(`LSC_OFS_CFG0, 32'h4);
    @(posedge sys_clk);
    lutIn[7:0] <= 8'h25;
    pulse(0);
    rd(`LSC_OFS_LUT0 + 8'h04, v);
    `CHK(v, 32'h228)
    `CHK(cellOut[1], 1'b0)
    // inverted idle clock holds the latch gate open; only the config write makes an edge
    wr(`LSC_OFS_CFG0, 32'h2048);
    @(posedge sys_clk);
    directIn[0] <= 1'b0;
    settle();
    `CHK(cellQ[0], 1'b0)
    @(posedge sys_clk);
    directIn[0] <= 1'b1;
    settle();
    `CHK(cellQ[0], 1'b1)
    $display("test pair done");
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // whole run is a few hundred cycles; this leaves wide margin
  initial begin
    #100000;
    errorCnt++;
    end_sim();
  end

  initial begin
    errorCnt    = 0;
    checked     = 0;
    sys_rst     = 1'b1;
    regAddr     = '0;
    regWdata    = '0;
    regWr       = 1'b0;
    regRd       = 1'b0;
    run         = 2'b00;
    sliceCe     = 2'b00;
    initForce   = 2'b00;
    invertForce = 2'b00;
    sliceWe     = 2'b00;
    f5Sel       = 2'b00;
    f6Sel       = 1'b0;
    carryIn     = 1'b0;
    lutIn       = '0;
    directIn    = '0;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_logic();
    t_direct();
    t_force();
    t_ram();
    t_shift();
    t_pair();
    end_sim();
  end
endmodule
